/* File: scf_pkg.sv */
package scf_pkg;

	// ==========================================================
	// Register map
	localparam logic [7:0] SCF_CFG_ADDR = 8'hc1;
	localparam logic [7:0] SCF_CFG_RESET = 8'h00;

	// ==========================================================
	// Field positions of the configuration register
	localparam int SCF_BIT_ENABLE = 7;
	localparam int SCF_BIT_INHIBIT = 6;
	localparam int SCF_BIT_BUSY = 5;
	localparam int SCF_BIT_SDA_HOLD_EXTEND = 4;
	localparam int SCF_BIT_LOWTO = 3;
	localparam int SCF_BIT_FREETO = 2;
	localparam int SCF_CS_LSB = 0;

	// ==========================================================
	// Clock source encodings
	localparam logic [1:0] SCF_CS_T0 = 2'h0;
	localparam logic [1:0] SCF_CS_T1 = 2'h1;
	localparam logic [1:0] SCF_CS_T2H = 2'h2;
	localparam logic [1:0] SCF_CS_T2L = 2'h3;

	// ==========================================================
	// Timing counts: hold and setup in system clocks, free timeout in tick periods
	localparam logic [4:0] SCF_HOLD_NORM = 5'h03;
	localparam logic [4:0] SCF_HOLD_EXT = 5'h0c;
	localparam logic [4:0] SCF_SETUP_NORM = 5'h01;
	localparam logic [4:0] SCF_SETUP_EXT = 5'h0b;
	localparam logic [3:0] SCF_FREE_PERIODS = 4'ha;

	// ==========================================================
	// Types
	typedef struct packed {
		logic scl;
		logic sda;
	} scf_pins_t;

	typedef struct packed {
		logic t0;
		logic t1;
		logic t2h;
		logic t2l;
	} scf_ovf_t;

	// Master line sequencer, gray along idle-start-low-high-stop
	typedef enum logic [2:0] {
		SCF_M_IDLE = 3'h0,
		SCF_M_START = 3'h1,
		SCF_M_LOW = 3'h3,
		SCF_M_HIGH = 3'h2,
		SCF_M_STOPL = 3'h6,
		SCF_M_STOPH = 3'h7
	} scf_mstate_t;

endpackage

/* File: scf_sync2.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Two-stage synchroniser for pin inputs
module scf_sync2 #(
	parameter int WIDTH = 2
) (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Data
	input wire logic [WIDTH-1:0] d,
	output logic [WIDTH-1:0] q
);

	logic [WIDTH-1:0] meta_q;

	// Lines idle high, so reset to ones avoids a false START
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			meta_q <= '1;
			q <= '1;
		end else begin
			meta_q <= d;
			q <= meta_q;
		end
	end

endmodule
`default_nettype wire

/* File: scf_config.sv */
// Function
// - Enable bit gates whole interface except addr_nack_force
// - Enabled interface always watches both lines
// - Inhibit masks slave interrupts, master unaffected
// - Busy bit set during bus transfer
// - Busy clears on STOP or free timeout
// - Extension bit selects SDA timing
// - Extended: setup 11, hold 12; else hold 3
// - Low timeout: timer 3 reload while SCL high
// - Split timer 3: only upper byte reloaded
// - Bus free after more than 10 periods high
// - Two bits choose overflow source for bit rate
// - SCL high at least one period; low until a tick is seen and hold plus setup met
// - Inhibited: NACK addresses, at once while idle, else from next START
// - Pending START issued right after free timeout
`timescale 1ns/1ps
`default_nettype none

module scf_config (
	// Clock and reset
	input wire logic clk,
	input wire logic rst_n,
	// Special-function register port
	input wire logic [7:0] sfr_addr,
	input wire logic sfr_wr,
	input wire logic sfr_rd,
	input wire logic [7:0] sfr_wdata,
	output logic [7:0] sfr_rdata,
	// Bus pins, open drain
	input wire scf_pkg::scf_pins_t pin_in,
	output scf_pkg::scf_pins_t pin_out,
	output scf_pkg::scf_pins_t pin_oe,
	// Timer overflow pulses
	input wire scf_pkg::scf_ovf_t ovf,
	// Timer 3 reload control
	input wire logic t3_split,
	output logic t3_reload_hi,
	output logic t3_reload_lo,
	// Transfer engine side
	input wire logic start_req,
	input wire logic stop_req,
	input wire logic tx_bit,
	output logic bit_done,
	output logic rx_bit,
	output logic start_seen,
	output logic stop_seen,
	// Slave event gating
	input wire logic slave_irq_in,
	input wire logic master_irq_in,
	output logic irq_out,
	output logic addr_nack_force
);

	// ==========================================================
	// Configuration register
	logic [7:0] cfg_q;
	logic busy_q;
	logic cfg_en, cfg_inh, cfg_ext, cfg_lowto, cfg_freeto;
	logic [1:0] cfg_cs;
	logic cfg_hit;

	assign cfg_hit = sfr_addr == scf_pkg::SCF_CFG_ADDR;
	assign cfg_en = cfg_q[scf_pkg::SCF_BIT_ENABLE];
	assign cfg_inh = cfg_q[scf_pkg::SCF_BIT_INHIBIT];
	assign cfg_ext = cfg_q[scf_pkg::SCF_BIT_SDA_HOLD_EXTEND];
	assign cfg_lowto = cfg_q[scf_pkg::SCF_BIT_LOWTO];
	assign cfg_freeto = cfg_q[scf_pkg::SCF_BIT_FREETO];
	assign cfg_cs = cfg_q[scf_pkg::SCF_CS_LSB +: 2];

	// Writable bits; the busy position is kept at zero here
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			cfg_q <= scf_pkg::SCF_CFG_RESET;
		end else if (sfr_wr && cfg_hit) begin
			cfg_q <= sfr_wdata & ~(8'h01 << scf_pkg::SCF_BIT_BUSY);
		end
	end

	// Read data, busy from hardware, unmapped reads zero
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			sfr_rdata <= 8'h00;
		end else if (sfr_rd) begin
			sfr_rdata <= cfg_hit ? (cfg_q | ({7'h00, busy_q} << scf_pkg::SCF_BIT_BUSY)) : 8'h00;
		end
	end

	// ==========================================================
	// Line monitor
	scf_pkg::scf_pins_t pin_s, pin_prev_q;

	scf_sync2 #(
		.WIDTH(2)
	) u_sync (
		.clk(clk),
		.rst_n(rst_n),
		.d(pin_in),
		.q(pin_s)
	);

	// Previous sample for START and STOP detection
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			pin_prev_q <= '1;
		end else begin
			pin_prev_q <= pin_s;
		end
	end

	// Watching needs no transfer in progress, only the enable
	assign start_seen = cfg_en && pin_s.scl && pin_prev_q.scl && pin_prev_q.sda && !pin_s.sda;
	assign stop_seen = cfg_en && pin_s.scl && pin_prev_q.scl && !pin_prev_q.sda && pin_s.sda;

	// ==========================================================
	// Clock source and free timeout
	logic tick;
	logic [3:0] free_cnt_q;
	logic free_to;

	always_comb begin
		case (cfg_cs)
			scf_pkg::SCF_CS_T0: tick = ovf.t0;
			scf_pkg::SCF_CS_T1: tick = ovf.t1;
			scf_pkg::SCF_CS_T2H: tick = ovf.t2h;
			scf_pkg::SCF_CS_T2L: tick = ovf.t2l;
			default: tick = 1'b0;
		endcase
	end

	// Count ticks while both lines high; the eleventh tick means more than ten
	assign free_to = cfg_en && cfg_freeto && busy_q && tick && pin_s.scl && pin_s.sda &&
		(free_cnt_q == scf_pkg::SCF_FREE_PERIODS);

	always_ff @(posedge clk) begin
		if (!rst_n || !cfg_en || !pin_s.scl || !pin_s.sda || !busy_q) begin
			free_cnt_q <= 4'h0;
		end else if (tick && free_cnt_q != scf_pkg::SCF_FREE_PERIODS) begin
			free_cnt_q <= free_cnt_q + 4'h1;
		end
	end

	// ==========================================================
	// Busy flag; a START in the same cycle beats the clear
	always_ff @(posedge clk) begin
		if (!rst_n || !cfg_en) begin
			busy_q <= 1'b0;
		end else if (start_seen) begin
			busy_q <= 1'b1;
		end else if (stop_seen || free_to) begin
			busy_q <= 1'b0;
		end
	end

	// ==========================================================
	// Slave inhibit, follows the bit while idle and is latched at each START during a transfer
	logic inh_eff_q;

	always_ff @(posedge clk) begin
		if (!rst_n) begin
			inh_eff_q <= 1'b0;
		end else if (start_seen || !busy_q) begin
			inh_eff_q <= cfg_inh;
		end
	end

	assign irq_out = cfg_en && (master_irq_in || (slave_irq_in && !inh_eff_q));
	assign addr_nack_force = inh_eff_q;

	// ==========================================================
	// Timer 3 reload for SCL low timeout
	assign t3_reload_hi = cfg_en && cfg_lowto && pin_s.scl;
	assign t3_reload_lo = cfg_en && cfg_lowto && pin_s.scl && !t3_split;

	// ==========================================================
	// Master line sequencer
	scf_pkg::scf_mstate_t mst_q;
	logic [4:0] cyc_q;
	logic ovf_seen_q;
	logic scl_drv_q, sda_drv_q;
	logic [4:0] hold_cnt, setup_cnt;
	logic go_next;

	assign hold_cnt = cfg_ext ? scf_pkg::SCF_HOLD_EXT : scf_pkg::SCF_HOLD_NORM;
	assign setup_cnt = cfg_ext ? scf_pkg::SCF_SETUP_EXT : scf_pkg::SCF_SETUP_NORM;

	// START and high phases end after one full tick period; low phases once a tick is seen and timing is met
	always_comb begin
		case (mst_q)
			scf_pkg::SCF_M_START: go_next = ovf_seen_q && tick;
			scf_pkg::SCF_M_LOW: go_next = ovf_seen_q && (cyc_q >= hold_cnt + setup_cnt);
			scf_pkg::SCF_M_HIGH: go_next = ovf_seen_q && tick && pin_s.scl;
			scf_pkg::SCF_M_STOPL: go_next = ovf_seen_q && (cyc_q >= hold_cnt + setup_cnt);
			scf_pkg::SCF_M_STOPH: go_next = ovf_seen_q && tick && pin_s.scl;
			default: go_next = 1'b0;
		endcase
	end

	// State register
	always_ff @(posedge clk) begin
		if (!rst_n || !cfg_en) begin
			mst_q <= scf_pkg::SCF_M_IDLE;
		end else begin
			case (mst_q)
				scf_pkg::SCF_M_IDLE: begin
					if (start_req && !busy_q) begin
						mst_q <= scf_pkg::SCF_M_START;
					end
				end
				scf_pkg::SCF_M_START: begin
					if (go_next) begin
						mst_q <= scf_pkg::SCF_M_LOW;
					end
				end
				scf_pkg::SCF_M_LOW: begin
					if (go_next) begin
						mst_q <= scf_pkg::SCF_M_HIGH;
					end
				end
				scf_pkg::SCF_M_HIGH: begin
					if (go_next) begin
						mst_q <= stop_req ? scf_pkg::SCF_M_STOPL : scf_pkg::SCF_M_LOW;
					end
				end
				scf_pkg::SCF_M_STOPL: begin
					if (go_next) begin
						mst_q <= scf_pkg::SCF_M_STOPH;
					end
				end
				scf_pkg::SCF_M_STOPH: begin
					if (go_next) begin
						mst_q <= scf_pkg::SCF_M_IDLE;
					end
				end
				default: mst_q <= scf_pkg::SCF_M_IDLE;
			endcase
		end
	end

	// Cycle count and tick seen within the current phase
	always_ff @(posedge clk) begin
		if (!rst_n || !cfg_en || go_next || mst_q == scf_pkg::SCF_M_IDLE) begin
			cyc_q <= 5'h00;
			ovf_seen_q <= 1'b0;
		end else begin
			if (cyc_q != 5'h1f) begin
				cyc_q <= cyc_q + 5'h01;
			end
			if (tick) begin
				ovf_seen_q <= 1'b1;
			end
		end
	end

	// SCL drive: low in low phases, released otherwise
	always_ff @(posedge clk) begin
		if (!rst_n || !cfg_en) begin
			scl_drv_q <= 1'b0;
		end else begin
			scl_drv_q <= (mst_q == scf_pkg::SCF_M_LOW || mst_q == scf_pkg::SCF_M_STOPL) &&
				!go_next;
		end
	end

	// In low phases SDA changes only after the hold count from SCL falling; START and STOP move it with SCL high
	always_ff @(posedge clk) begin
		if (!rst_n || !cfg_en) begin
			sda_drv_q <= 1'b0;
		end else begin
			case (mst_q)
				scf_pkg::SCF_M_START: sda_drv_q <= 1'b1;
				scf_pkg::SCF_M_LOW: begin
					if (cyc_q == hold_cnt) begin
						sda_drv_q <= !tx_bit;
					end
				end
				scf_pkg::SCF_M_STOPL: begin
					if (cyc_q == hold_cnt) begin
						sda_drv_q <= 1'b1;
					end
				end
				scf_pkg::SCF_M_STOPH: begin
					if (go_next) begin
						sda_drv_q <= 1'b0;
					end
				end
				scf_pkg::SCF_M_HIGH: sda_drv_q <= sda_drv_q;
				default: sda_drv_q <= 1'b0;
			endcase
		end
	end

	// Sampled bit at the end of each high phase
	always_ff @(posedge clk) begin
		if (!rst_n) begin
			bit_done <= 1'b0;
			rx_bit <= 1'b0;
		end else begin
			bit_done <= mst_q == scf_pkg::SCF_M_HIGH && go_next;
			if (mst_q == scf_pkg::SCF_M_HIGH && go_next) begin
				rx_bit <= pin_s.sda;
			end
		end
	end

	// Open drain: output data always low, enable means pull low
	assign pin_out = '0;
	assign pin_oe = '{scl: scl_drv_q, sda: sda_drv_q};

	// ==========================================================
	// Checks
	logic [4:0] low_len_q;

	always_ff @(posedge clk) begin
		if (!rst_n || !scl_drv_q) begin
			low_len_q <= 5'h00;
		end else if (low_len_q != 5'h1f) begin
			low_len_q <= low_len_q + 5'h01;
		end
	end

	chk_busy_ro_write: assert property (@(posedge clk) disable iff (!rst_n)
		sfr_wr && cfg_hit |=> !cfg_q[scf_pkg::SCF_BIT_BUSY])
		else $error("busy position stored from a write");
	chk_disable_release: assert property (@(posedge clk) disable iff (!rst_n)
		!cfg_en |=> !pin_oe.scl && !pin_oe.sda && mst_q == scf_pkg::SCF_M_IDLE)
		else $error("lines not released after disable");
	chk_busy_set_start: assert property (@(posedge clk) disable iff (!rst_n)
		start_seen |=> busy_q)
		else $error("busy not set by start");
	chk_busy_clr_stop: assert property (@(posedge clk) disable iff (!rst_n)
		busy_q && stop_seen && !start_seen |=> !busy_q)
		else $error("busy not cleared by stop");
	chk_inhibit_irq_mask: assert property (@(posedge clk) disable iff (!rst_n)
		inh_eff_q && !master_irq_in |-> !irq_out)
		else $error("slave interrupt passed while inhibited");
	chk_reload_split: assert property (@(posedge clk) disable iff (!rst_n)
		t3_split |-> !t3_reload_lo)
		else $error("low byte reloaded in split mode");
	chk_reload_scl_low: assert property (@(posedge clk) disable iff (!rst_n)
		t3_reload_hi |-> pin_s.scl && cfg_lowto)
		else $error("timer 3 reload while SCL low");
	chk_hold_time: assert property (@(posedge clk) disable iff (!rst_n)
		scl_drv_q && $changed(sda_drv_q) && mst_q != scf_pkg::SCF_M_IDLE |-> low_len_q >= hold_cnt)
		else $error("SDA changed inside hold window");
	chk_setup_release: assert property (@(posedge clk) disable iff (!rst_n)
		$fell(scl_drv_q) && cfg_en |-> $past(low_len_q) >= hold_cnt + setup_cnt - 5'h01)
		else $error("SCL released before setup time");
	chk_free_clears: assert property (@(posedge clk) disable iff (!rst_n)
		free_to && !start_seen |=> !busy_q)
		else $error("free timeout did not clear busy");

endmodule
`default_nettype wire

/* File: scf_bus_model.sv */
`timescale 1ns/1ps
`default_nettype none

// ==========================================================
// Other agent on the wires: open drain, it only pulls low
module scf_bus_model (
	// Clock
	input wire logic clk,
	// Pulls, high while holding the line low
	output logic scl_pull,
	output logic sda_pull
);
	// Released at time zero, lines sit at the pull-up level
	initial begin
		scl_pull = 1'b0;
		sda_pull = 1'b0;
	end

	// One line step, then half of the 80 ns link period
	// Clock only moves inside frames and the s_reload steps, never free running
	task automatic step(input logic c, input logic d);
		@(posedge clk);
		scl_pull <= c;
		sda_pull <= d;
		repeat (4) @(posedge clk);
	endtask
endmodule

`default_nettype wire

/* File: tb.sv */
`timescale 1ns/1ps
`default_nettype none

module tb;
	// ==========================================================
	// Signals
	localparam logic [7:0] A = scf_pkg::SCF_CFG_ADDR;
	logic clk, rst_n, sfr_wr, sfr_rd, t3_split, start_req, stop_req, tx_bit;
	logic slave_irq_in, master_irq_in, t3_reload_hi, t3_reload_lo, bit_done, rx_bit;
	logic start_seen, stop_seen, irq_out, addr_nack_force, scl_pull, sda_pull, tick_run;
	logic [7:0] sfr_addr, sfr_wdata, sfr_rdata, rd;
	logic [2:0] tcnt;
	scf_pkg::scf_pins_t pin_in, pin_out, pin_oe;
	scf_pkg::scf_ovf_t ovf, tick_mask;
	int ticks, mismatches, checks, n;

	// Wired-AND with pull-ups on both lines
	assign pin_in.scl = ~(pin_oe.scl | scl_pull);
	assign pin_in.sda = ~(pin_oe.sda | sda_pull);

	scf_config u_scf_config (.clk(clk), .rst_n(rst_n), .sfr_addr(sfr_addr),
		.sfr_wr(sfr_wr), .sfr_rd(sfr_rd), .sfr_wdata(sfr_wdata), .sfr_rdata(sfr_rdata),
		.pin_in(pin_in), .pin_out(pin_out), .pin_oe(pin_oe), .ovf(ovf),
		.t3_split(t3_split), .t3_reload_hi(t3_reload_hi), .t3_reload_lo(t3_reload_lo),
		.start_req(start_req), .stop_req(stop_req), .tx_bit(tx_bit), .bit_done(bit_done),
		.rx_bit(rx_bit), .start_seen(start_seen), .stop_seen(stop_seen),
		.slave_irq_in(slave_irq_in), .master_irq_in(master_irq_in), .irq_out(irq_out),
		.addr_nack_force(addr_nack_force));
	scf_bus_model u_scf_bus_model (.clk(clk), .scl_pull(scl_pull), .sda_pull(sda_pull));

	// ==========================================================
	// Timer overflow source, one pulse every 8 clocks while running
	always @(posedge clk) begin
		tcnt <= tcnt + 3'h1;
		ovf <= (tick_run && tcnt == 3'h7) ? tick_mask : 4'h0;
		ticks <= !tick_run ? 0 : (tcnt == 3'h7) ? ticks + 1 : ticks;
	end

	// ==========================================================
	// Helpers
	task automatic test_done();
		$display("checks %0d mismatches %0d", checks, mismatches);
		if (mismatches == 0 && checks > 0) begin
			$display("NO MISMATCHES");
		end else begin
			$display("MISMATCHES SEEN");
		end
		$finish;
	endtask
	task automatic chk(input string what, input logic [7:0] exp, input logic [7:0] got);
		checks++;
		if (got !== exp) begin
			mismatches++;
			$display("[ERR] %s expected %h seen %h", what, exp, got);
		end
	endtask
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge clk);
		sfr_wr <= 1'b1;
		sfr_addr <= a;
		sfr_wdata <= d;
		@(posedge clk);
		sfr_wr <= 1'b0;
	endtask
	task automatic rdr(input logic [7:0] a);
		@(posedge clk);
		sfr_rd <= 1'b1;
		sfr_addr <= a;
		@(posedge clk);
		sfr_rd <= 1'b0;
		#1 rd = sfr_rdata;
	endtask
	task automatic bsy(input logic exp);
		rdr(A);
		chk("busy", {7'h00, exp}, {7'h00, rd[scf_pkg::SCF_BIT_BUSY]});
	endtask
	function automatic logic sg(input int k);
		return k == 0 ? pin_oe.sda : k == 1 ? pin_oe.scl : bit_done;
	endfunction
	// Bounded wait; a run-out ends the test as a mismatch
	task automatic wsig(input int k, input logic v);
		n = 0;
		while (sg(k) !== v && n < 600) begin
			@(posedge clk);
			#1 n++;
		end
		if (n >= 600) begin
			mismatches++;
			test_done();
		end
	endtask
	task automatic wtick(input int t);
		n = 0;
		while (ticks < t && n < 400) begin
			@(posedge clk);
			#1 n++;
		end
		if (n >= 400) begin
			mismatches++;
			test_done();
		end
	endtask
	// Partner START, then SDA up under SCL low: both high, no STOP
	task automatic frame();
		u_scf_bus_model.step(1'b0, 1'b1);
		u_scf_bus_model.step(1'b1, 1'b1);
		u_scf_bus_model.step(1'b1, 1'b0);
		u_scf_bus_model.step(1'b0, 1'b0);
	endtask

	// ==========================================================
	// Scenarios
	task automatic s_regs();
		rdr(A);
		chk("cfg reset", 8'h00, rd);
		rdr(8'hc0);
		chk("unmapped", 8'h00, rd);
		wr(A, 8'hff);
		rdr(A);
		chk("cfg rw", 8'hdf, rd);
		wr(A, 8'h08);
		#1 chk("reload off", 8'h00, {7'h00, t3_reload_hi});
	endtask
	task automatic s_reload();
		wr(A, 8'h88);
		#1 chk("reload hi", 8'h01, {7'h00, t3_reload_hi});
		chk("reload lo", 8'h01, {7'h00, t3_reload_lo});
		t3_split <= 1'b1;
		@(posedge clk);
		#1 chk("split hi", 8'h01, {7'h00, t3_reload_hi});
		chk("split lo", 8'h00, {7'h00, t3_reload_lo});
		u_scf_bus_model.step(1'b1, 1'b0);
		chk("scl low hi", 8'h00, {7'h00, t3_reload_hi});
		u_scf_bus_model.step(1'b0, 1'b0);
		t3_split <= 1'b0;
	endtask
	task automatic s_busy();
		wr(A, 8'h00);
		u_scf_bus_model.step(1'b0, 1'b1);
		bsy(1'b0);
		u_scf_bus_model.step(1'b0, 1'b0);
		wr(A, 8'h80);
		u_scf_bus_model.step(1'b0, 1'b1);
		bsy(1'b1);
		u_scf_bus_model.step(1'b0, 1'b0);
		bsy(1'b0);
	endtask
	task automatic s_inhibit();
		wr(A, 8'hc0);
		slave_irq_in <= 1'b1;
		@(posedge clk);
		#1 chk("slave irq", 8'h00, {7'h00, irq_out});
		master_irq_in <= 1'b1;
		@(posedge clk);
		#1 chk("master irq", 8'h01, {7'h00, irq_out});
		master_irq_in <= 1'b0;
		frame();
		chk("nack", 8'h01, {7'h00, addr_nack_force});
		u_scf_bus_model.step(1'b0, 1'b1);
		u_scf_bus_model.step(1'b0, 1'b0);
		wr(A, 8'h80);
		@(posedge clk);
		#1 chk("slave irq on", 8'h01, {7'h00, irq_out});
		slave_irq_in <= 1'b0;
	endtask
	task automatic s_free(input logic [1:0] cs);
		wr(A, 8'h84 | {6'h00, cs});
		frame();
		tick_mask <= 4'h8 >> (cs + 2'h1);
		tick_run <= 1'b1;
		wtick(12);
		bsy(1'b1);
		tick_run <= 1'b0;
		tick_mask <= 4'h8 >> cs;
		@(posedge clk);
		tick_run <= 1'b1;
		wtick(10);
		bsy(1'b1);
		start_req <= (cs == 2'h3);
		wtick(11);
		repeat (4) @(posedge clk);
		if (cs != 2'h3) begin
			bsy(1'b0);
		end else begin
			#1 chk("start after free", 8'h01, {7'h00, pin_oe.sda});
			start_req <= 1'b0;
			wr(A, 8'h00);
			@(posedge clk);
			#1 chk("released", 8'h00, {6'h00, pin_oe});
		end
		tick_run <= 1'b0;
	endtask
	task automatic s_master(input logic ext);
		wr(A, {3'h4, ext, 4'h0});
		tick_mask <= 4'h8;
		tick_run <= 1'b1;
		tx_bit <= 1'b1;
		stop_req <= 1'b1;
		start_req <= 1'b1;
		wsig(0, 1'b1);
		wsig(1, 1'b1);
		wsig(0, 1'b0);
		chk("hold", {3'h0, ext ? scf_pkg::SCF_HOLD_EXT : scf_pkg::SCF_HOLD_NORM}, n[7:0]);
		start_req <= 1'b0;
		wsig(2, 1'b1);
		chk("rx bit", 8'h01, {7'h00, rx_bit});
		wsig(0, 1'b1);
		wsig(0, 1'b0);
		chk("stop lines", 8'h00, {6'h00, pin_oe});
		chk("pin out", 8'h00, {6'h00, pin_out});
		// STOP needs the two sync stages before busy drops
		repeat (3) @(posedge clk);
		bsy(1'b0);
		tick_run <= 1'b0;
		stop_req <= 1'b0;
	endtask

	// ==========================================================
	// Clock, reset and main sequence
	initial begin
		clk = 1'b0;
		forever #5 clk = ~clk;
	end
	initial begin
		{rst_n, sfr_wr, sfr_rd, t3_split, start_req, stop_req, tx_bit} = 7'h00;
		{slave_irq_in, master_irq_in, tick_run} = 3'h0;
		{sfr_addr, sfr_wdata, tcnt, ovf, tick_mask} = 27'h0;
		ticks = 0;
		mismatches = 0;
		checks = 0;
		repeat (8) @(posedge clk);
		rst_n <= 1'b1;
		s_regs();
		s_reload();
		s_busy();
		s_inhibit();
		for (int i = 0; i < 4; i++) begin
			s_free(i[1:0]);
		end
		s_master(1'b0);
		s_master(1'b1);
		test_done();
	end
endmodule

`default_nettype wire
